// ---- core/ptc_pkg.sv ----
// Purpose: Constants for the pulse-train position command input stage
// Assumes: 40 MHz aclk, AXI4-Lite register access, 12-bit byte addresses
// Notes:   Option fields are 4-bit nibbles x, y, z, u from low to high
package ptc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int ACC_W = 32;
  localparam int POS_SEL_W = 6;
  localparam int TGT_DEPTH = 64;
  localparam int FLT_CNT_W = 6;
  localparam int SYNC_W = 14;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL_PEND = 12'h000;
  localparam logic [11:0] ADDR_PULSE_PEND = 12'h004;
  localparam logic [11:0] ADDR_CTRL_ACT = 12'h008;
  localparam logic [11:0] ADDR_PULSE_ACT = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_ACCUM = 12'h014;
  localparam logic [11:0] ADDR_POS_CMD = 12'h018;
  localparam logic [11:0] ADDR_TGT_BASE = 12'h400;
  localparam logic [11:0] ADDR_TGT_MASK = 12'h0ff;
  localparam int TGT_IDX_LSB = 2;
  // Option nibble positions
  localparam int FLD_X = 0;
  localparam int FLD_Y = 4;
  localparam int FLD_Z = 8;
  localparam int FLD_U = 12;
  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PULSE_RESET = 16'h0000;
  // Field encodings
  localparam logic [3:0] MODE_POSITION = 4'h0;
  localparam logic [3:0] SEL_EXTERNAL = 4'h0;
  localparam logic [3:0] SEL_INTERNAL = 4'h1;
  localparam logic [3:0] FMT_FWD_REV = 4'h0;
  localparam logic [3:0] FMT_PULSE_SIGN = 4'h1;
  localparam logic [3:0] FMT_QUAD = 4'h2;
  localparam logic [3:0] POL_NEGATIVE = 4'h1;
  localparam logic [3:0] FILT_SLOW = 4'h1;
  localparam logic [3:0] SRC_HIGH_SPEED = 4'h1;
  // Filter timing: accept a level stable for a quarter of the pulse period
  localparam int CLK_PERIOD_NS = 25;
  localparam int LS_FAST_PERIOD_NS = 2000;
  localparam int LS_SLOW_PERIOD_NS = 5000;
  localparam int HS_PERIOD_NS = 250;
  localparam int LS_FAST_CYC = LS_FAST_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam int LS_SLOW_CYC = LS_SLOW_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam int HS_CYC = HS_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- core/ptc_top.sv ----
// Purpose: Position command input stage: pulse decoder, source select, regs
// Assumes: Pins are asynchronous; aresetn is the power cycle of the drive
// Notes:   Pending options survive aresetn, cleared only by power_on_resetn
`timescale 1ns/1ps
module ptc_top
(
  // Clock and resets
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         power_on_resetn,
  // AXI4-Lite write
  input  wire logic [ptc_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [ptc_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ptc_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [ptc_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // Pulse pins
  input  wire logic                         low_speed_forward_pos,
  input  wire logic                         low_speed_forward_neg,
  input  wire logic                         low_speed_reverse_pos,
  input  wire logic                         low_speed_reverse_neg,
  input  wire logic                         high_speed_forward_pos,
  input  wire logic                         high_speed_forward_neg,
  input  wire logic                         high_speed_reverse_pos,
  input  wire logic                         high_speed_reverse_neg,
  // Position select inputs, bit 0 is position_select_bit0
  input  wire logic [ptc_pkg::POS_SEL_W-1:0] position_select,
  // Command outputs
  output logic [ptc_pkg::ACC_W-1:0]         position_command,
  output logic                              external_pulse_mode,
  output logic                              smoothing_bypass
);
  import ptc_pkg::*;

  logic [SYNC_W-1:0]    sync1;
  logic [SYNC_W-1:0]    sync2;
  logic [15:0]          ctrl_pend;
  logic [15:0]          pulse_pend;
  logic [15:0]          ctrl_act;
  logic [15:0]          pulse_act;
  logic                 cfg_loaded;
  logic                 armed;
  logic                 ext_mode;
  logic                 int_mode;
  logic [3:0]           fmt;
  logic                 neg_logic;
  logic [FLT_CNT_W-1:0] limit;
  logic [1:0]           raw;
  logic [1:0]           flt;
  logic [FLT_CNT_W-1:0] flt_cnt [2];
  logic [1:0]           lv;
  logic [1:0]           prev;
  logic [1:0]           rise;
  logic                 step_up;
  logic                 step_dn;
  logic [ACC_W-1:0]     accum;
  logic [DATA_W-1:0]    tgt [TGT_DEPTH];
  logic [DATA_W-1:0]    tgt_sel;
  logic [ADDR_W-1:0]    aw_addr;
  logic [DATA_W-1:0]    w_data;
  logic [3:0]           w_strb;
  logic                 aw_full;
  logic                 w_full;
  logic                 do_write;
  logic                 next_aw_full;
  logic                 next_w_full;
  logic                 next_rvalid;
  logic                 wr_tgt;
  logic                 rd_tgt;

  // Two-stage synchronisers for every pin
  always_ff @(posedge aclk)
  begin
    sync1 <= {position_select,
              high_speed_reverse_neg, high_speed_reverse_pos,
              high_speed_forward_neg, high_speed_forward_pos,
              low_speed_reverse_neg, low_speed_reverse_pos,
              low_speed_forward_neg, low_speed_forward_pos};
    sync2 <= sync1;
  end

  // Pending options live across aresetn, as a nonvolatile store would
  always_ff @(posedge aclk)
  begin
    if (!power_on_resetn)
    begin
      ctrl_pend  <= CTRL_RESET;
      pulse_pend <= PULSE_RESET;
    end
    else if (do_write)
    begin
      if (aw_addr == ADDR_CTRL_PEND)
      begin
        if (w_strb[0]) ctrl_pend[7:0] <= w_data[7:0];
        if (w_strb[1]) ctrl_pend[15:8] <= w_data[15:8];
      end
      if (aw_addr == ADDR_PULSE_PEND)
      begin
        if (w_strb[0]) pulse_pend[7:0] <= w_data[7:0];
        if (w_strb[1]) pulse_pend[15:8] <= w_data[15:8];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_act   <= CTRL_RESET;
      pulse_act  <= PULSE_RESET;
      cfg_loaded <= 1'b0;
      armed      <= 1'b0;
    end
    else
    begin
      if (!cfg_loaded)
      begin
        ctrl_act  <= ctrl_pend;
        pulse_act <= pulse_pend;
      end
      cfg_loaded <= 1'b1;
      armed      <= cfg_loaded;
    end
  end

  assign ext_mode = armed &&
    ctrl_act[FLD_X +: 4] == MODE_POSITION &&
    ctrl_act[FLD_Y +: 4] == SEL_EXTERNAL;
  assign int_mode = armed &&
    ctrl_act[FLD_X +: 4] == MODE_POSITION &&
    ctrl_act[FLD_Y +: 4] == SEL_INTERNAL;
  assign fmt       = pulse_act[FLD_X +: 4];
  assign neg_logic = pulse_act[FLD_Y +: 4] == POL_NEGATIVE;

  assign raw = (pulse_act[FLD_U +: 4] == SRC_HIGH_SPEED) ?
    {sync2[6] & ~sync2[7], sync2[4] & ~sync2[5]} :
    {sync2[2] & ~sync2[3], sync2[0] & ~sync2[1]};

  always_comb
  begin
    if (pulse_act[FLD_U +: 4] == SRC_HIGH_SPEED)
      limit = FLT_CNT_W'(HS_CYC);
    else if (pulse_act[FLD_Z +: 4] == FILT_SLOW)
      limit = FLT_CNT_W'(LS_SLOW_CYC);
    else
      limit = FLT_CNT_W'(LS_FAST_CYC);
  end

  // Glitch filter: a level must hold for limit cycles before it is taken
  for (genvar g = 0; g < 2; g++)
  begin : g_flt
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        flt[g]     <= 1'b0;
        flt_cnt[g] <= '0;
      end
      else if (raw[g] == flt[g])
        flt_cnt[g] <= '0;
      else if (flt_cnt[g] >= limit - 1'b1)
      begin
        flt[g]     <= raw[g];
        flt_cnt[g] <= '0;
      end
      else
        flt_cnt[g] <= flt_cnt[g] + 1'b1;
    end
  end

  assign lv   = neg_logic ? ~flt : flt;
  assign rise = lv & ~prev;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev <= 2'b00;
    else
      prev <= lv;
  end

  always_comb
  begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case (fmt)
      FMT_FWD_REV:
      begin
        step_up = rise[0] & ~rise[1];
        step_dn = rise[1] & ~rise[0];
      end
      FMT_PULSE_SIGN:
      begin
        step_up = rise[0] & ~lv[1];
        step_dn = rise[0] & lv[1];
      end
      // phase order, x4 decode; a double change is dropped
      FMT_QUAD:
      begin
        step_up = ((lv ^ prev) != 2'b11) && (lv != prev) &&
                  (prev[0] == lv[1]);
        step_dn = ((lv ^ prev) != 2'b11) && (lv != prev) &&
                  (prev[0] != lv[1]);
      end
      default:
      begin
        step_up = 1'b0;
        step_dn = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      accum <= '0;
    else if (ext_mode && step_up)
      accum <= accum + 1'b1;
    else if (ext_mode && step_dn)
      accum <= accum - 1'b1;
  end

  assign tgt_sel = tgt[sync2[8 +: POS_SEL_W]];

  // Command mux; holds last value in any other mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      position_command    <= '0;
      external_pulse_mode <= 1'b0;
      smoothing_bypass    <= 1'b0;
    end
    else
    begin
      if (ext_mode)
        position_command <= accum;
      else if (int_mode)
        position_command <= tgt_sel;
      external_pulse_mode <= ext_mode;
      smoothing_bypass    <= ext_mode;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  assign do_write     = aw_full && w_full && !s_axi_bvalid;
  assign next_aw_full = (aw_full | (s_axi_awvalid & s_axi_awready)) &
                        ~do_write;
  assign next_w_full  = (w_full | (s_axi_wvalid & s_axi_wready)) &
                        ~do_write;
  assign wr_tgt = (aw_addr & ~ADDR_TGT_MASK) == ADDR_TGT_BASE;
  assign rd_tgt = (s_axi_araddr & ~ADDR_TGT_MASK) == ADDR_TGT_BASE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= 4'h0;
    end
    else
    begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= ~next_aw_full;
      s_axi_wready  <= ~next_w_full;
      if (s_axi_awvalid && s_axi_awready)
        aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_tgt || aw_addr == ADDR_CTRL_PEND ||
                         aw_addr == ADDR_PULSE_PEND) ?
                        RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Target registers, byte-lane writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < TGT_DEPTH; i++)
        tgt[i] <= '0;
    end
    else if (do_write && wr_tgt)
    begin
      for (int b = 0; b < 4; b++)
        if (w_strb[b])
          tgt[aw_addr[TGT_IDX_LSB +: POS_SEL_W]][b*8 +: 8] <=
            w_data[b*8 +: 8];
    end
  end

  // AXI4-Lite read path, answer one cycle after the address is taken
  assign next_rvalid = (s_axi_rvalid & ~s_axi_rready) |
                       (s_axi_arvalid & s_axi_arready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rresp <= RESP_OKAY;
        if (rd_tgt)
          s_axi_rdata <= tgt[s_axi_araddr[TGT_IDX_LSB +: POS_SEL_W]];
        else
          case (s_axi_araddr)
            ADDR_CTRL_PEND:  s_axi_rdata <= {16'h0000, ctrl_pend};
            ADDR_PULSE_PEND: s_axi_rdata <= {16'h0000, pulse_pend};
            ADDR_CTRL_ACT:   s_axi_rdata <= {16'h0000, ctrl_act};
            ADDR_PULSE_ACT:  s_axi_rdata <= {16'h0000, pulse_act};
            ADDR_STATUS:     s_axi_rdata <= {29'h0000000, int_mode,
                                             ext_mode, cfg_loaded};
            ADDR_ACCUM:      s_axi_rdata <= accum;
            ADDR_POS_CMD:    s_axi_rdata <= position_command;
            default:
            begin
              s_axi_rdata <= '0;
              s_axi_rresp <= RESP_SLVERR;
            end
          endcase
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ext_cmd;
    ext_mode |=> position_command == $past(accum);
  endproperty
  a_ext_cmd: assert property (p_ext_cmd)
    else $error("pulse mode command not from accumulator");

  property p_int_cmd;
    int_mode |=> position_command == $past(tgt_sel);
  endproperty
  a_int_cmd: assert property (p_int_cmd)
    else $error("internal mode command not from selected set");

  property p_ctrl_hold;
    cfg_loaded |=> $stable(ctrl_act);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control option changed while running");

  property p_pulse_hold;
    cfg_loaded |=> $stable(pulse_act);
  endproperty
  a_pulse_hold: assert property (p_pulse_hold)
    else $error("pulse option changed while running");

  property p_bypass;
    armed |=> smoothing_bypass == $past(ext_mode);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("smoothing bypass does not follow pulse mode");

  property p_fr_up;
    ext_mode && fmt == FMT_FWD_REV && rise == 2'b01
      |=> accum == $past(accum) + 1'b1;
  endproperty
  a_fr_up: assert property (p_fr_up)
    else $error("forward edge did not add one");

  property p_ps_dn;
    ext_mode && fmt == FMT_PULSE_SIGN && rise[0] && lv[1]
      |=> accum == $past(accum) - 1'b1;
  endproperty
  a_ps_dn: assert property (p_ps_dn)
    else $error("pulse with sign high did not subtract one");

  property p_filter;
    cfg_loaded && flt[0] != $past(flt[0])
      |-> $past(flt_cnt[0]) == $past(limit) - 1'b1;
  endproperty
  a_filter: assert property (p_filter)
    else $error("filter output changed before its limit");

  property p_no_ext;
    external_pulse_mode |-> $past(ctrl_act[FLD_X +: 4]) == MODE_POSITION;
  endproperty
  a_no_ext: assert property (p_no_ext)
    else $error("pulse mode active with non-zero mode field");

  c_fr: cover property (ext_mode && fmt == FMT_FWD_REV && step_up);
  c_quad: cover property (ext_mode && fmt == FMT_QUAD && step_dn);
  c_int: cover property (int_mode ##1 $changed(position_command));
  c_wr: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
endmodule

// ---- testbench/ptc_host_model.sv ----
// Purpose: Host controller model driving the command pulse pins
// Assumes: Line-driver outputs, negative leg is the inverse level
// Notes:   Positive legs idle low; pins change only right after aclk rising edges
`timescale 1ns/1ps
module ptc_host_model
(
  // Clock
  input  wire logic aclk,
  // Low-speed pins
  output logic      low_speed_forward_pos,
  output logic      low_speed_forward_neg,
  output logic      low_speed_reverse_pos,
  output logic      low_speed_reverse_neg,
  // High-speed pins
  output logic      high_speed_forward_pos,
  output logic      high_speed_forward_neg,
  output logic      high_speed_reverse_pos,
  output logic      high_speed_reverse_neg
);
  logic la = 1'b0;
  logic lb = 1'b0;
  logic ha = 1'b0;
  logic hb = 1'b0;
  assign low_speed_forward_pos = la;
  assign low_speed_forward_neg = ~la;
  assign low_speed_reverse_pos = lb;
  assign low_speed_reverse_neg = ~lb;
  assign high_speed_forward_pos = ha;
  assign high_speed_forward_neg = ~ha;
  assign high_speed_reverse_pos = hb;
  assign high_speed_reverse_neg = ~hb;
  // host rate limit
  // Callers hold low-speed levels 40 cycles or more (500 kpps, a line
  // driver's ceiling); only a deliberate reset-time change is shorter
  task automatic drive(input logic hs, input logic a, input logic b,
                       input int w);
    if (hs)
    begin
      ha <= a;
      hb <= b;
    end
    else
    begin
      la <= a;
      lb <= b;
    end
    repeat (w) @(posedge aclk);
  endtask
endmodule

// ---- testbench/ptc_top_tb.sv ----
// Purpose: Self-checking bench for the pulse command input stage
// Assumes: 40 MHz aclk, host model on the pulse pins
// Notes:   Bus answers are checked from queues by a negedge monitor
`timescale 1ns/1ps
module ptc_top_tb;
  import ptc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic por_n = 1'b0;
  logic [11:0] awa = '0;
  logic [11:0] ara = '0;
  logic [31:0] wd = '0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bre = 1'b0;
  logic arv = 1'b0;
  logic rre = 1'b0;
  logic [5:0] psel = '0;
  logic awr, wr, bv, arr, rv, epm, sbp;
  logic [1:0] brs, rrs;
  logic [31:0] rd, pcmd;
  logic lfp, lfn, lrp, lrn, hfp, hfn, hrp, hrn;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [31:0] seed = 32'h0a6e;
  logic [31:0] tv;
  logic [1:0] qs [12] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b10, 2'b11,
                          2'b01, 2'b00, 2'b01, 2'b11, 2'b10, 2'b00};
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;

  always #12.5 aclk = ~aclk;

  ptc_top ptc_top_i
  (
    .aclk(aclk), .aresetn(aresetn), .power_on_resetn(por_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(brs), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rrs),
    .s_axi_rvalid(rv), .s_axi_rready(rre),
    .low_speed_forward_pos(lfp), .low_speed_forward_neg(lfn),
    .low_speed_reverse_pos(lrp), .low_speed_reverse_neg(lrn),
    .high_speed_forward_pos(hfp), .high_speed_forward_neg(hfn),
    .high_speed_reverse_pos(hrp), .high_speed_reverse_neg(hrn),
    .position_select(psel), .position_command(pcmd),
    .external_pulse_mode(epm), .smoothing_bypass(sbp)
  );

  ptc_host_model ptc_host_model_i
  (
    .aclk(aclk),
    .low_speed_forward_pos(lfp), .low_speed_forward_neg(lfn),
    .low_speed_reverse_pos(lrp), .low_speed_reverse_neg(lrn),
    .high_speed_forward_pos(hfp), .high_speed_forward_neg(hfn),
    .high_speed_reverse_pos(hrp), .high_speed_reverse_neg(hrn)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string n, input logic [33:0] e,
                     input logic [33:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Handshakes are sampled at negedge, the level the next rising edge sees
  always @(negedge aclk)
  begin
    if (bv && bre)
      chk("bresp", {32'h0, bq.pop_front()}, {32'h0, brs});
    if (rv && rre)
      chk("rdata", rq.pop_front(), {rrs, rd});
  end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      close_out();
    end
  end

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] e);
    logic [2:0] hs;
    bq.push_back(e);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    hs = '0;
    while (!hs[0])
    begin
      @(negedge aclk);
      hs = {awv & awr, wv & wr, bre & bv};
      @(posedge aclk);
      if (hs[2])
        awv <= 1'b0;
      if (hs[1])
        wv <= 1'b0;
      if (hs[0])
        bre <= 1'b0;
    end
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [33:0] e);
    logic [1:0] hs;
    rq.push_back(e);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    hs = '0;
    while (!hs[0])
    begin
      @(negedge aclk);
      hs = {arv & arr, rre & rv};
      @(posedge aclk);
      if (hs[1])
        arv <= 1'b0;
      if (hs[0])
        rre <= 1'b0;
    end
    @(posedge aclk);
  endtask

  task automatic pcycle();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Filter restarts from low; let it relearn idle levels before pulses
    repeat (60) @(posedge aclk);
  endtask

  // Pulse pair: active levels act, then idle levels idl, n times
  task automatic pul(input logic hs, input logic [1:0] act,
                     input logic [1:0] idl, input int n, input int w);
    repeat (n)
    begin
      ptc_host_model_i.drive(hs, act[1], act[0], w);
      ptc_host_model_i.drive(hs, idl[1], idl[0], w);
    end
  endtask

  task automatic acc_chk(input logic [31:0] v);
    rd_chk(ADDR_ACCUM, {RESP_OKAY, v});
    chk("pcmd", {2'b00, v}, {2'b00, pcmd});
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(posedge aclk);
    // Reset values and default pulse mode
    rd_chk(ADDR_CTRL_PEND, {RESP_OKAY, 16'h0, CTRL_RESET});
    rd_chk(ADDR_PULSE_PEND, {RESP_OKAY, 16'h0, PULSE_RESET});
    rd_chk(ADDR_STATUS, {RESP_OKAY, 32'h3});
    chk("sbp", 34'h1, {33'h0, sbp});
    // Forward/reverse, rising edges, low-speed pins only
    pul(1'b0, 2'b10, 2'b00, 3, 100);
    pul(1'b0, 2'b01, 2'b00, 1, 100);
    pul(1'b1, 2'b10, 2'b00, 2, 100);
    acc_chk(32'h2);
    rd_chk(ADDR_POS_CMD, {RESP_OKAY, 32'h2});
    // Unmapped and read-only places
    rd_chk(12'h020, {RESP_SLVERR, 32'h0});
    wr_chk(ADDR_STATUS, 32'h0, RESP_SLVERR);
    // Slow filter pending: old filter still in force
    wr_chk(ADDR_PULSE_PEND, 32'hffff0100, RESP_OKAY);
    rd_chk(ADDR_PULSE_PEND, {RESP_OKAY, 32'h0100});
    // 40-cycle levels: full 500 kpps, passes fast filter, not slow one
    pul(1'b0, 2'b10, 2'b00, 1, 40);
    acc_chk(32'h3);
    pcycle();
    rd_chk(ADDR_PULSE_ACT, {RESP_OKAY, 32'h0100});
    pul(1'b0, 2'b10, 2'b00, 1, 40);
    pul(1'b0, 2'b10, 2'b00, 1, 100);
    acc_chk(32'h1);
    // Pulse plus sign, falling edges
    wr_chk(ADDR_PULSE_PEND, 32'h0011, RESP_OKAY);
    ptc_host_model_i.drive(1'b0, 1'b1, 1'b1, 10);
    pcycle();
    pul(1'b0, 2'b01, 2'b11, 3, 100);
    ptc_host_model_i.drive(1'b0, 1'b1, 1'b0, 100);
    pul(1'b0, 2'b00, 2'b10, 1, 100);
    acc_chk(32'h2);
    // Quadrature on high-speed pins, low-speed pins ignored
    wr_chk(ADDR_PULSE_PEND, 32'h1002, RESP_OKAY);
    ptc_host_model_i.drive(1'b0, 1'b0, 1'b0, 10);
    pcycle();
    for (int i = 0; i < 12; i++)
      ptc_host_model_i.drive(1'b1, qs[i][1], qs[i][0], 40);
    pul(1'b0, 2'b10, 2'b00, 2, 100);
    acc_chk(32'h4);
    // Internal register mode, pending until power cycle
    wr_chk(ADDR_CTRL_PEND, 32'h0010, RESP_OKAY);
    rd_chk(ADDR_CTRL_ACT, {RESP_OKAY, 32'h0});
    chk("epm", 34'h1, {33'h0, epm});
    pcycle();
    chk("epm", 34'h0, {33'h0, epm});
    chk("sbp", 34'h0, {33'h0, sbp});
    rd_chk(ADDR_STATUS, {RESP_OKAY, 32'h5});
    for (int i = 0; i < 64; i += 21)
    begin
      seed = lfsr(seed);
      tv = seed;
      wr_chk(ADDR_TGT_BASE + 12'(4 * i), tv, RESP_OKAY);
      rd_chk(ADDR_TGT_BASE + 12'(4 * i), {RESP_OKAY, tv});
      psel <= 6'(i);
      repeat (8) @(posedge aclk);
      chk("pcmd", {2'b00, tv}, {2'b00, pcmd});
    end
    // Non-position mode selects neither source, then pending store cleared by power-on
    wr_chk(ADDR_CTRL_PEND, 32'h0001, RESP_OKAY);
    pcycle();
    rd_chk(ADDR_STATUS, {RESP_OKAY, 32'h1});
    chk("epm", 34'h0, {33'h0, epm});
    por_n <= 1'b0;
    repeat (2) @(posedge aclk);
    por_n <= 1'b1;
    rd_chk(ADDR_CTRL_PEND, {RESP_OKAY, 32'h0});
    pcycle();
    chk("epm", 34'h1, {33'h0, epm});
    close_out();
  end
endmodule
